// file: pkg/ccr_params.svh
// Purpose: Offsets, reset values and field positions of the charge counter readout.
// Assumes: Byte-wide registers addressed by an 8-bit register index.
// Notes: Definitions only.
`ifndef CCR_PARAMS_SVH
`define CCR_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CCR_OFF_B_SLEEP_HIGH 8'h17
`define CCR_OFF_B_SLEEP_LOW 8'h18
`define CCR_OFF_C_COUNT_HIGH 8'h19
`define CCR_OFF_C_COUNT_LOW 8'h1A
`define CCR_OFF_SUPPLY_AVG_HIGH 8'h1B

// ----------------------------------------
// Reset values and fields
// ----------------------------------------
`define CCR_RST_BYTE 8'h00
`define CCR_RST_COUNT 16'h0000
`define CCR_RST_NIBBLE 4'h0
`define CCR_CNT_HIGH_MSB 15
`define CCR_CNT_HIGH_LSB 8
`define CCR_CNT_LOW_MSB 7
`define CCR_CNT_LOW_LSB 0
`define CCR_NIBBLE_MSB 3
`define CCR_NIBBLE_LSB 0
`define CCR_CH_B 0
`define CCR_CH_C 1

`endif

// file: pkg/ccr_pkg.sv
// Purpose: Types shared by the charge counter readout.
// Assumes: Register access arrives already decoded from the serial control bus.
// Notes: Offsets and counts live in ccr_params.svh.
`default_nettype none
package ccr_pkg;

	// Register access as presented by the serial bus slave
	typedef struct packed
	{
		logic active;
		logic read;
		logic [7:0] addr;
	} ccr_bus_s;

	// Use of the output-C counter
	typedef enum logic [1:0]
	{
		CCR_CHARGE,
		CCR_CALIBRATING,
		CCR_CAL_RESULT
	} ccr_cal_e;

endpackage

`default_nettype wire

// file: src/ccr_charge_counter_readout.sv
// Purpose: Read-only charge counter registers with coherent two-byte reads.
// Assumes: Bus, pulses and calibration strobes are on core_clk; reference clock is not.
// Notes: Output B high byte at 0x17 is readable and its read also loads the low-byte shadow.
//
// What this block does
// - Output-B sleep counter low byte is read-only, reset 0x00.
// - Output-C counter readable: high byte 0x19, low byte 0x1A, reset zero.
// - One count per N pulses, N chosen by the counter prescaler.
// - Counts are 16-bit values split over two byte registers.
// - Addressing a counter register freezes that counter; counts meanwhile are lost.
// - Reading a high byte copies the live low byte into a shadow.
// - Reading a low byte returns its shadow, not the live count.
// - During calibration output-C counter counts 10 MHz reference cycles.
// - After calibration, output-C holds the reference count until counter clear or the next calibration event.
// - Offset 0x1B: bits 7:4 read zero, bits 3:0 supply average nibble.
`timescale 1ns/100ps
`default_nettype none
`include "ccr_params.svh"

module ccr_charge_counter_readout
#(
	parameter int PRE_W = 3
)
(
	input wire logic core_clk,
	input wire logic rst,
	input wire ccr_pkg::ccr_bus_s busReq,
	input wire logic [PRE_W-1:0] counterPrescaler,
	input wire logic [1:0] pfmPulse,
	input wire logic calEvent,
	input wire logic counterClearEvent,
	input wire logic refClkPin,
	input wire logic [3:0] supplyAvgHighNibble,
	output logic [7:0] rdData,
	output logic rdValid,
	output logic calResultHeld
);
	import ccr_pkg::*;

	localparam int DIV_W = 1 << PRE_W;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	function automatic logic isHigh(input logic [7:0] addr, input int ch);
		isHigh = (ch == `CCR_CH_C) ? (addr == `CCR_OFF_C_COUNT_HIGH)
			: (addr == `CCR_OFF_B_SLEEP_HIGH);
	endfunction

	function automatic logic isLow(input logic [7:0] addr, input int ch);
		isLow = (ch == `CCR_CH_C) ? (addr == `CCR_OFF_C_COUNT_LOW)
			: (addr == `CCR_OFF_B_SLEEP_LOW);
	endfunction

	function automatic logic chanHit(input logic [7:0] addr, input int ch);
		chanHit = isHigh(addr, ch) || isLow(addr, ch);
	endfunction

	// ----------------------------------------
	// Reference clock synchroniser
	// ----------------------------------------
	logic refMeta;
	logic refSync;
	logic refLast;
	logic refRise;
	logic next_refMeta;
	logic next_refSync;
	logic next_refLast;

	always_comb
	begin
		next_refMeta = refClkPin;
		next_refSync = refMeta;
		next_refLast = refSync;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			refMeta <= 1'b0;
			refSync <= 1'b0;
			refLast <= 1'b0;
		end
		else
		begin
			refMeta <= next_refMeta;
			refSync <= next_refSync;
			refLast <= next_refLast;
		end
	end

	assign refRise = refSync && !refLast;

	// ----------------------------------------
	// Calibration state of output-C counter
	// ----------------------------------------
	ccr_cal_e calState;
	ccr_cal_e next_calState;
	logic next_calResultHeld;
	logic calStart;

	assign calStart = calEvent && (calState != CCR_CALIBRATING);

	always_comb
	begin
		next_calState = calState;
		unique case (calState)
			CCR_CHARGE:
				if (calEvent)
					next_calState = CCR_CALIBRATING;
			CCR_CALIBRATING:
				if (!calEvent)
					next_calState = CCR_CAL_RESULT;
			CCR_CAL_RESULT:
				if (calEvent)
					next_calState = CCR_CALIBRATING;
			// Unused fourth code falls back to charge counting
			default:
				next_calState = CCR_CHARGE;
		endcase
		// Clear ends any calibration use of the counter
		if (counterClearEvent)
			next_calState = CCR_CHARGE;
		next_calResultHeld = (next_calState == CCR_CAL_RESULT);
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			calState <= CCR_CHARGE;
			calResultHeld <= 1'b0;
		end
		else
		begin
			calState <= next_calState;
			calResultHeld <= next_calResultHeld;
		end
	end

	// ----------------------------------------
	// Counters, prescalers and shadows
	// ----------------------------------------
	logic [1:0][15:0] cntBus;
	logic [1:0][7:0] shadowBus;
	logic [1:0] preWrap;
	logic [1:0] inhibit;
	logic [1:0] countEvt;

	for (genvar ch = 0; ch < 2; ch++)
	begin : gChan
		logic [15:0] cnt;
		logic [15:0] next_cnt;
		logic [DIV_W-1:0] preCnt;
		logic [DIV_W-1:0] next_preCnt;
		logic [DIV_W-1:0] preLimit;
		logic [7:0] shadow;
		logic [7:0] next_shadow;
		logic calOwned;
		logic evt;
		logic wrap;
		logic inh;

		always_comb
		begin
			preLimit = DIV_W'(1) << counterPrescaler;
			calOwned = (ch == `CCR_CH_C) && (calState != CCR_CHARGE);
			// Prescaler keeps running while frozen, so only whole counts are lost
			wrap = pfmPulse[ch] && (preCnt == DIV_W'(preLimit - DIV_W'(1)));
			next_preCnt = preCnt;
			if (counterClearEvent)
				next_preCnt = '0;
			else if (pfmPulse[ch] && !calOwned)
				next_preCnt = wrap ? '0 : DIV_W'(preCnt + DIV_W'(1));
			evt = calOwned ? ((calState == CCR_CALIBRATING) && refRise)
				: wrap;
			inh = busReq.active && chanHit(busReq.addr, ch);
			next_cnt = cnt;
			if (counterClearEvent)
				next_cnt = `CCR_RST_COUNT;
			else if ((ch == `CCR_CH_C) && calStart)
				next_cnt = `CCR_RST_COUNT;
			else if (evt && !inh)
				next_cnt = 16'(cnt + 16'h0001);
			next_shadow = shadow;
			if (busReq.read && isHigh(busReq.addr, ch))
				next_shadow = cnt[`CCR_CNT_LOW_MSB:`CCR_CNT_LOW_LSB];
		end

		always_ff @(posedge core_clk)
		begin
			if (rst)
			begin
				cnt <= `CCR_RST_COUNT;
				preCnt <= '0;
				shadow <= `CCR_RST_BYTE;
			end
			else
			begin
				cnt <= next_cnt;
				preCnt <= next_preCnt;
				shadow <= next_shadow;
			end
		end

		assign cntBus[ch] = cnt;
		assign shadowBus[ch] = shadow;
		assign preWrap[ch] = wrap;
		assign inhibit[ch] = inh;
		assign countEvt[ch] = evt;
	end

	// ----------------------------------------
	// Read data path
	// ----------------------------------------
	logic [7:0] next_rdData;
	logic next_rdValid;

	always_comb
	begin
		next_rdValid = busReq.read;
		next_rdData = rdData;
		if (busReq.read)
		begin
			unique case (busReq.addr)
				`CCR_OFF_B_SLEEP_HIGH:
					next_rdData = cntBus[`CCR_CH_B][`CCR_CNT_HIGH_MSB:`CCR_CNT_HIGH_LSB];
				`CCR_OFF_B_SLEEP_LOW:
					next_rdData = shadowBus[`CCR_CH_B];
				`CCR_OFF_C_COUNT_HIGH:
					next_rdData = cntBus[`CCR_CH_C][`CCR_CNT_HIGH_MSB:`CCR_CNT_HIGH_LSB];
				`CCR_OFF_C_COUNT_LOW:
					next_rdData = shadowBus[`CCR_CH_C];
				`CCR_OFF_SUPPLY_AVG_HIGH:
					next_rdData = {`CCR_RST_NIBBLE, supplyAvgHighNibble};
				default:
					next_rdData = `CCR_RST_BYTE;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			rdData <= `CCR_RST_BYTE;
			rdValid <= 1'b0;
		end
		else
		begin
			rdData <= next_rdData;
			rdValid <= next_rdValid;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	AST_RESET_ZERO: assert property (disable iff (1'b0) rst |=> (cntBus == '0) && (rdData == 8'h00))
		else $error("Counters or read data not zero after reset");
	AST_INHIBIT_HOLDS: assert property ((inhibit[1] && !counterClearEvent && !calStart)
		|=> $stable(cntBus[1]))
		else $error("Output-C counter moved while addressed");
	AST_RESUME: assert property ((countEvt[0] && !inhibit[0] && !counterClearEvent)
		|=> cntBus[0] == 16'($past(cntBus[0]) + 16'h0001))
		else $error("Output-B counter missed a count while not addressed");
	AST_PRESCALE: assert property ((calState == CCR_CHARGE && !preWrap[1] && !counterClearEvent
		&& !calStart) |=> $stable(cntBus[1]))
		else $error("Counter advanced without a full prescaler period");
	AST_SHADOW_CAPTURE: assert property ((busReq.read && busReq.addr == 8'h19)
		|=> shadowBus[1] == $past(cntBus[1][7:0]))
		else $error("High byte read did not capture low byte");
	AST_LOW_FROM_SHADOW: assert property ((busReq.read && busReq.addr == 8'h1A)
		|=> rdValid && rdData == $past(shadowBus[1]))
		else $error("Low byte read did not return the shadow");
	AST_HIGH_READ: assert property ((busReq.read && busReq.addr == 8'h17)
		|=> rdData == $past(cntBus[0][15:8]))
		else $error("High byte read returned wrong byte");
	AST_CAL_COUNT: assert property ((calState == CCR_CALIBRATING && refRise && !inhibit[1]
		&& !counterClearEvent) |=> cntBus[1] == 16'($past(cntBus[1]) + 16'h0001))
		else $error("Reference edge not counted during calibration");
	AST_CAL_HOLD: assert property ((calState == CCR_CAL_RESULT && !calEvent && !counterClearEvent)
		|=> $stable(cntBus[1]) && calResultHeld)
		else $error("Calibration result not held");
	AST_CLEAR: assert property (counterClearEvent |=> cntBus == '0 && !calResultHeld)
		else $error("Clear did not end calibration result");
	AST_AVG_REG: assert property ((busReq.read && busReq.addr == 8'h1B)
		|=> rdData[7:4] == 4'h0 && rdData[3:0] == $past(supplyAvgHighNibble))
		else $error("Supply nibble register wrong");
	AST_READ_ANSWER: assert property (rdValid == $past(busReq.read))
		else $error("Read answer valid not one cycle after the read");

	COV_COHERENT_READ: cover property ((busReq.read && busReq.addr == 8'h19)
		##[1:20] (busReq.read && busReq.addr == 8'h1A));
	COV_CAL_DONE: cover property (calState == CCR_CALIBRATING ##1 calState == CCR_CAL_RESULT);
	COV_LOST_COUNT: cover property (inhibit[0] && countEvt[0]);

endmodule

`default_nettype wire

// file: sim/ccr_host_model.sv
// Purpose: Host processor issuing register reads to the counter readout.
// Assumes: Reads follow the one-cycle read pulse and registered answer.
// Notes: Released address shows the inverse of the last one.
`timescale 1ns/100ps
`default_nettype none

module ccr_host_model
(
	input wire logic core_clk,
	output var ccr_pkg::ccr_bus_s busReq,
	input wire logic [7:0] rdData,
	input wire logic rdValid
);
	import ccr_pkg::*;

	initial busReq = '{active: 1'b0, read: 1'b0, addr: 8'h00};

	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge core_clk);
		busReq <= '{active: 1'b1, read: 1'b1, addr: a};
		@(posedge core_clk);
		busReq.read <= 1'b0;
		@(posedge core_clk);
		d = rdData;
		v = rdValid;
		// Drop the access at once so counting is not held off
		busReq <= '{active: 1'b0, read: 1'b0, addr: ~a};
	endtask

	task automatic park(input logic [7:0] a);
		@(posedge core_clk);
		busReq <= '{active: 1'b1, read: 1'b0, addr: a};
	endtask

	task automatic unpark();
		@(posedge core_clk);
		busReq <= '{active: 1'b0, read: 1'b0, addr: ~busReq.addr};
	endtask
endmodule

`default_nettype wire

// file: sim/tb_ccr_charge_counter_readout.sv
// Purpose: Self-checking bench for the charge counter readout.
// Assumes: Reference clock runs free at 10 MHz.
// Notes: Calibration window spans 20 reference periods.
`timescale 1ns/100ps
`default_nettype none

module tb_ccr_charge_counter_readout;
	import ccr_pkg::*;

	logic core_clk = 1'b0;
	logic rst = 1'b1;
	ccr_bus_s busReq;
	logic [2:0] counterPrescaler = 3'h0;
	logic [1:0] pfmPulse = 2'h0;
	logic calEvent = 1'b0;
	logic counterClearEvent = 1'b0;
	logic refClkPin = 1'b0;
	logic [3:0] supplyAvgHighNibble = 4'h0;
	logic [7:0] rdData;
	logic rdValid;
	logic calResultHeld;
	int failures = 0;
	int n_tests = 0;

	always #5 core_clk = ~core_clk;
	// Offset start keeps reference phase unrelated to core_clk
	initial #3 forever #50 refClkPin = ~refClkPin;

	ccr_charge_counter_readout #(.PRE_W(3)) u_ccr_charge_counter_readout (
		.core_clk(core_clk), .rst(rst), .busReq(busReq),
		.counterPrescaler(counterPrescaler), .pfmPulse(pfmPulse),
		.calEvent(calEvent), .counterClearEvent(counterClearEvent),
		.refClkPin(refClkPin), .supplyAvgHighNibble(supplyAvgHighNibble),
		.rdData(rdData), .rdValid(rdValid), .calResultHeld(calResultHeld));

	ccr_host_model u_ccr_host_model (.core_clk(core_clk), .busReq(busReq),
		.rdData(rdData), .rdValid(rdValid));

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		n_tests++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chkrng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
		n_tests++;
		if ($isunknown(got) || got < lo || got > hi)
		begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic v;
		u_ccr_host_model.rd(a, d, v);
		chk1(v, 1'b1);
		chk8(d, exp);
	endtask

	task automatic pulse(input logic [1:0] m, input int n);
		repeat (n)
		begin
			@(posedge core_clk);
			pfmPulse <= m;
		end
		@(posedge core_clk);
		pfmPulse <= 2'h0;
	endtask

	task automatic sc_count();
		pulse(2'b01, 5);
		rdchk(8'h17, 8'h00);
		rdchk(8'h18, 8'h05);
		counterPrescaler <= 3'h2;
		pulse(2'b10, 8);
		rdchk(8'h19, 8'h00);
		rdchk(8'h1A, 8'h02);
	endtask

	task automatic sc_shadow();
		rdchk(8'h19, 8'h00);
		pulse(2'b10, 4);
		rdchk(8'h1A, 8'h02);
		rdchk(8'h19, 8'h00);
		rdchk(8'h1A, 8'h03);
	endtask

	task automatic sc_inhibit();
		u_ccr_host_model.park(8'h1A);
		pulse(2'b11, 4);
		u_ccr_host_model.unpark();
		rdchk(8'h19, 8'h00);
		rdchk(8'h1A, 8'h03);
		rdchk(8'h17, 8'h00);
		rdchk(8'h18, 8'h06);
	endtask

	task automatic sc_cal();
		logic [7:0] h;
		logic [7:0] l;
		logic v;
		rdchk(8'h19, 8'h00);
		rdchk(8'h1A, 8'h03);
		@(posedge core_clk);
		calEvent <= 1'b1;
		pulse(2'b10, 8);
		repeat (191) @(posedge core_clk);
		calEvent <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk1(calResultHeld, 1'b1);
		u_ccr_host_model.rd(8'h19, h, v);
		chk1(v, 1'b1);
		u_ccr_host_model.rd(8'h1A, l, v);
		chk1(v, 1'b1);
		chkrng({h, l}, 16'h0013, 16'h0015);
		@(posedge core_clk);
		counterClearEvent <= 1'b1;
		@(posedge core_clk);
		counterClearEvent <= 1'b0;
		@(posedge core_clk);
		chk1(calResultHeld, 1'b0);
		rdchk(8'h19, 8'h00);
		rdchk(8'h1A, 8'h00);
		rdchk(8'h17, 8'h00);
		rdchk(8'h18, 8'h00);
	endtask

	task automatic sc_misc();
		supplyAvgHighNibble <= 4'hA;
		rdchk(8'h1B, 8'h0A);
		rdchk(8'h40, 8'h00);
	endtask

	task automatic tally_and_finish();
		if (failures == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		chk1(calResultHeld, 1'b0);
		rdchk(8'h18, 8'h00);
		rdchk(8'h19, 8'h00);
		rdchk(8'h1A, 8'h00);
		rdchk(8'h1B, 8'h00);
		sc_count();
		sc_shadow();
		sc_inhibit();
		sc_cal();
		sc_misc();
		tally_and_finish();
	end
endmodule

`default_nettype wire
